// ==== verilog/aisd_pkg.sv ====
// Package: constants and types for the converter input select block
package aisd_pkg;

  // ==========================================================
  // Basic types
  typedef logic [3:0]  aisd_addr_t;
  typedef logic [15:0] aisd_word_t;
  typedef logic [5:0]  aisd_ain_t;

  // ==========================================================
  // Register offsets (word index on the register port)
  localparam aisd_addr_t ADDR_DMA_CFG = 4'h0;
  localparam aisd_addr_t ADDR_MULTI   = 4'h1;
  localparam aisd_addr_t ADDR_CH0     = 4'h2;
  localparam aisd_addr_t ADDR_CTRL    = 4'h3;

  // Implemented bits of each register
  localparam aisd_word_t MASK_DMA_CFG = 16'h0107;
  localparam aisd_word_t MASK_MULTI   = 16'h1f1f;
  localparam aisd_word_t MASK_CH0     = 16'hbfbf;
  localparam aisd_word_t MASK_CTRL    = 16'hffff;
  localparam aisd_word_t WORD_ZERO    = 16'h0000;

  // ==========================================================
  // Field positions
  localparam int DMA_EN_BIT = 8;
  localparam int BWPI_LSB   = 0;
  localparam int M_SB_HI    = 11;
  localparam int M_NB       = 9;
  localparam int M_SB_LO    = 8;
  localparam int M_SA_HI    = 3;
  localparam int M_NA       = 1;
  localparam int M_SA_LO    = 0;
  localparam int C0_NB      = 15;
  localparam int C0_SB      = 8;
  localparam int C0_NA      = 7;
  localparam int C0_SA      = 0;
  localparam int CT_REF     = 0;
  localparam int CT_ALTERNATE_SAMPLE_MODE    = 3;
  localparam int CT_CNT     = 4;
  localparam int CT_INC     = 6;
  localparam int CT_12B     = 11;
  localparam int CT_OPA     = 12;

  // ==========================================================
  // Analog inputs and select codes
  localparam aisd_ain_t AIN_0  = 6'h00;
  localparam aisd_ain_t AIN_1  = 6'h01;
  localparam aisd_ain_t AIN_2  = 6'h02;
  localparam aisd_ain_t AIN_3  = 6'h03;
  localparam aisd_ain_t AIN_4  = 6'h04;
  localparam aisd_ain_t AIN_5  = 6'h05;
  localparam aisd_ain_t AIN_6  = 6'h06;
  localparam aisd_ain_t AIN_7  = 6'h07;
  localparam aisd_ain_t AIN_8  = 6'h08;
  localparam aisd_ain_t AIN_9  = 6'h09;
  localparam aisd_ain_t AIN_10 = 6'h0a;
  localparam aisd_ain_t AIN_11 = 6'h0b;
  localparam aisd_ain_t AIN_25 = 6'h19;
  localparam aisd_ain_t POS_NONE   = 6'h3f;
  localparam aisd_ain_t POS_TEMP   = 6'h3e;
  localparam aisd_ain_t POS_RSV_LO = 6'h32;
  localparam aisd_ain_t POS_10B_LO = 6'h20;
  localparam aisd_ain_t POS_10B_HI = 6'h31;

  localparam int         MP_TOP   = 2;
  localparam logic [1:0] MP_AN012 = 2'b00;
  localparam logic [1:0] MP_AN345 = 2'b01;
  localparam logic [1:0] MP_OA_A  = 2'b10;
  localparam logic [1:0] MP_OA_B  = 2'b11;
  localparam logic [1:0] MN_HIGH  = 2'b11;
  localparam logic [1:0] MN_MID   = 2'b10;

  // Op amp mode bit index for each shared input
  localparam int OPA1 = 0;
  localparam int OPA2 = 1;
  localparam int OPA3 = 2;
  localparam int OPA5 = 3;

  localparam logic [2:0] REF_EXT_A = 3'h2;
  localparam logic [2:0] REF_EXT_B = 3'h3;

  localparam logic [1:0] CNT_CH0   = 2'b00;
  localparam logic [1:0] CNT_CH01  = 2'b01;
  localparam logic [3:0] CH_EN_ONE = 4'h1;
  localparam logic [3:0] CH_EN_TWO = 4'h3;
  localparam logic [3:0] CH_EN_ALL = 4'hf;

  localparam logic [7:0] BUF_WORDS_RST = 8'h01;
  localparam logic [3:0] IDX_ZERO = 4'h0;
  localparam logic [3:0] IDX_STEP = 4'h1;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_STEP = 5'h01;

  // ==========================================================
  // Decoded routing types
  typedef enum logic [1:0] {
    RT_PIN   = 2'b00,
    RT_OPAMP = 2'b01,
    RT_TEMP  = 2'b10,
    RT_NONE  = 2'b11
  } aisd_route_t;

  typedef enum logic [1:0] {
    NG_INPUT   = 2'b00,
    NG_EXT_REF = 2'b01,
    NG_GROUND  = 2'b10
  } aisd_neg_t;

  typedef enum logic {
    SET_A = 1'b0,
    SET_B = 1'b1
  } aisd_set_t;

  typedef struct packed {
    aisd_route_t route;
    aisd_ain_t   ain;
  } aisd_pos_t;

  typedef struct packed {
    aisd_neg_t kind;
    aisd_ain_t ain;
  } aisd_nsel_t;

  typedef struct packed {
    aisd_pos_t             ch0_pos;
    aisd_nsel_t            ch0_neg;
    aisd_pos_t  [2:0]      m_pos;
    aisd_nsel_t [2:0]      m_neg;
  } aisd_dec_t;

endpackage

// ==== verilog/aisd_sel_if.sv ====
// Interface: selection fields to the decoder and decoded routing back
`timescale 1ns/1ns
`default_nettype none
interface aisd_sel_if;
  aisd_pkg::aisd_ain_t pos_code;
  logic                neg_bit;
  logic [2:0]          multi_pos;
  logic [1:0]          multi_neg;
  logic [2:0]          ref_cfg;
  logic [3:0]          opamp_mode;
  logic                twelve_bit;
  aisd_pkg::aisd_dec_t dec;

  modport ctrl (
    output pos_code, neg_bit, multi_pos, multi_neg,
    output ref_cfg, opamp_mode, twelve_bit,
    input  dec
  );
  modport decode (
    input  pos_code, neg_bit, multi_pos, multi_neg,
    input  ref_cfg, opamp_mode, twelve_bit,
    output dec
  );
endinterface // aisd_sel_if
`default_nettype wire

// ==== verilog/aisd_sel_decode.sv ====
// Module: decodes one sample set into analog multiplexer routing
`timescale 1ns/1ns
`default_nettype none
module aisd_sel_decode (
  // Fields in, routing out
  aisd_sel_if.decode sel
);

  // ==========================================================
  // Helpers
  function automatic aisd_pkg::aisd_pos_t pin_or_opamp(
    input aisd_pkg::aisd_ain_t ain,
    input logic [3:0]          mode
  );
    aisd_pkg::aisd_pos_t p;
    p.ain   = ain;
    p.route = aisd_pkg::RT_PIN;
    if ((ain == aisd_pkg::AIN_3 && mode[aisd_pkg::OPA1]) ||
        (ain == aisd_pkg::AIN_0 && mode[aisd_pkg::OPA2]) ||
        (ain == aisd_pkg::AIN_6 && mode[aisd_pkg::OPA3]) ||
        (ain == aisd_pkg::AIN_25 && mode[aisd_pkg::OPA5])) begin
      p.route = aisd_pkg::RT_OPAMP;
    end
    return p;
  endfunction

  function automatic aisd_pkg::aisd_neg_t low_ref(input logic [2:0] cfg);
    if (cfg == aisd_pkg::REF_EXT_A || cfg == aisd_pkg::REF_EXT_B) begin
      return aisd_pkg::NG_EXT_REF;
    end
    return aisd_pkg::NG_GROUND;
  endfunction

  // ==========================================================
  // Decode
  aisd_pkg::aisd_ain_t [2:0] m_ain;
  aisd_pkg::aisd_ain_t [2:0] n_ain;
  aisd_pkg::aisd_dec_t       d;

  always_comb begin
    d = '0;
    d.ch0_pos.ain = sel.pos_code;
    if (sel.pos_code == aisd_pkg::POS_NONE) begin
      d.ch0_pos.route = aisd_pkg::RT_NONE;
    end else if (sel.pos_code == aisd_pkg::POS_TEMP) begin
      d.ch0_pos.route = aisd_pkg::RT_TEMP;
    end else if (sel.pos_code >= aisd_pkg::POS_RSV_LO) begin
      d.ch0_pos.route = aisd_pkg::RT_NONE;
    end else if (sel.twelve_bit && sel.pos_code >= aisd_pkg::POS_10B_LO) begin
      d.ch0_pos.route = aisd_pkg::RT_NONE;
    end else begin
      d.ch0_pos = pin_or_opamp(sel.pos_code, sel.opamp_mode);
    end
    if (sel.neg_bit) begin
      d.ch0_neg.kind = aisd_pkg::NG_INPUT;
      d.ch0_neg.ain  = aisd_pkg::AIN_1;
    end else begin
      d.ch0_neg.kind = low_ref(sel.ref_cfg);
      d.ch0_neg.ain  = aisd_pkg::AIN_0;
    end
    // Index 0 is channel 1, index 2 is channel 3
    if (sel.multi_pos[aisd_pkg::MP_TOP]) begin
      m_ain = {aisd_pkg::AIN_6, aisd_pkg::AIN_25, aisd_pkg::AIN_0};
    end else begin
      unique case (sel.multi_pos[aisd_pkg::MP_TOP-1:0])
        aisd_pkg::MP_AN012: m_ain = {aisd_pkg::AIN_2, aisd_pkg::AIN_1, aisd_pkg::AIN_0};
        aisd_pkg::MP_AN345: m_ain = {aisd_pkg::AIN_5, aisd_pkg::AIN_4, aisd_pkg::AIN_3};
        aisd_pkg::MP_OA_A:  m_ain = {aisd_pkg::AIN_6, aisd_pkg::AIN_0, aisd_pkg::AIN_3};
        aisd_pkg::MP_OA_B:  m_ain = {aisd_pkg::AIN_25, aisd_pkg::AIN_0, aisd_pkg::AIN_3};
      endcase
    end
    if (sel.multi_neg == aisd_pkg::MN_HIGH) begin
      n_ain = {aisd_pkg::AIN_11, aisd_pkg::AIN_10, aisd_pkg::AIN_9};
    end else begin
      n_ain = {aisd_pkg::AIN_8, aisd_pkg::AIN_7, aisd_pkg::AIN_6};
    end
    for (int i = 0; i < 3; i++) begin
      d.m_pos[i] = pin_or_opamp(m_ain[i], sel.opamp_mode);
      if (sel.multi_neg == aisd_pkg::MN_HIGH || sel.multi_neg == aisd_pkg::MN_MID) begin
        d.m_neg[i].kind = aisd_pkg::NG_INPUT;
        d.m_neg[i].ain  = n_ain[i];
      end else begin
        d.m_neg[i].kind = low_ref(sel.ref_cfg);
        d.m_neg[i].ain  = aisd_pkg::AIN_0;
      end
    end
  end

  assign sel.dec = d;

endmodule // aisd_sel_decode
`default_nettype wire

// ==== verilog/aisd_top.sv ====
// Module: converter input select, result buffer and DMA configuration
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - DMA enabled: every result to first buffer
// - DMA disabled: results fill sixteen buffers, no DMA
// - Buffer words per input is two^field
// - Three-bit multi select from split fields
// - Multi code 000 routes inputs 0,1,2
// - Multi code 001 routes inputs 3,4,5
// - Codes 010/011 route 3,0,6 and 3,0,25
// - Multi top bit set routes 0,25,6
// - Multi negative picks 9-11, 6-8, low reference
// - Low reference external only for config 2,3
// - Channel 0 negative bit: input 1 or reference
// - Channel 0 positive code n selects input n
// - Codes 63 unconnected, 62 temperature, 50-61 reserved
// - Shared inputs use op amp when mode set
// - Inputs 32-49 only in 10-bit mode
// - DMA address advances every rate+1 operations
// - Alternate mode swaps sets each sample
// - Channel count selects active channels in 10-bit mode; 12-bit mode enables channel 0 only
module aisd_top (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  // Register port
  input  wire aisd_pkg::aisd_addr_t reg_addr,
  input  wire aisd_pkg::aisd_word_t reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  aisd_pkg::aisd_word_t reg_rdata,
  // Conversion sequencing
  input  wire logic                 op_done,
  // Routing and result control
  output var  aisd_pkg::aisd_dec_t  sel_dec,
  output var  aisd_pkg::aisd_set_t  sel_set,
  output var  logic [3:0]           chan_enable,
  output var  logic [3:0]           buf_index,
  output var  logic                 dma_advance,
  output var  logic [7:0]           buffer_words
);

  // ==========================================================
  // State
  typedef struct packed {
    aisd_pkg::aisd_word_t dma_cfg;
    aisd_pkg::aisd_word_t multi;
    aisd_pkg::aisd_word_t ch0;
    aisd_pkg::aisd_word_t ctrl;
    aisd_pkg::aisd_word_t rdata;
    aisd_pkg::aisd_set_t  set;
    aisd_pkg::aisd_dec_t  dec;
    logic [3:0]           buf_idx;
    logic [4:0]           inc_cnt;
    logic                 dma_adv;
    logic [7:0]           words;
    logic [3:0]           ch_en;
  } aisd_state_t;

  aisd_state_t st_reg;
  aisd_state_t st_next;

  // ==========================================================
  // Field views
  logic                dma_en;
  logic [2:0]          bw_code;
  logic [2:0]          ref_cfg;
  logic                alternate_sample_mode;
  logic [1:0]          ch_cnt;
  logic [4:0]          inc_rate;
  logic                twelve;
  logic [3:0]          opa_mode;
  aisd_pkg::aisd_set_t nxt_set;

  assign dma_en   = st_reg.dma_cfg[aisd_pkg::DMA_EN_BIT];
  assign bw_code  = st_reg.dma_cfg[aisd_pkg::BWPI_LSB +: 3];
  assign ref_cfg  = st_reg.ctrl[aisd_pkg::CT_REF +: 3];
  assign alternate_sample_mode     = st_reg.ctrl[aisd_pkg::CT_ALTERNATE_SAMPLE_MODE];
  assign ch_cnt   = st_reg.ctrl[aisd_pkg::CT_CNT +: 2];
  assign inc_rate = st_reg.ctrl[aisd_pkg::CT_INC +: 5];
  assign twelve   = st_reg.ctrl[aisd_pkg::CT_12B];
  assign opa_mode = st_reg.ctrl[aisd_pkg::CT_OPA +: 4];

  // Set used by the next operation
  always_comb begin
    nxt_set = aisd_pkg::SET_A;
    if (alternate_sample_mode && st_reg.set == aisd_pkg::SET_A) begin
      nxt_set = aisd_pkg::SET_B;
    end
  end

  function automatic logic [3:0] chan_map(input logic [1:0] cnt, input logic tw);
    if (tw || cnt == aisd_pkg::CNT_CH0) begin
      return aisd_pkg::CH_EN_ONE;
    end
    if (cnt == aisd_pkg::CNT_CH01) begin
      return aisd_pkg::CH_EN_TWO;
    end
    return aisd_pkg::CH_EN_ALL;
  endfunction

  // ==========================================================
  // Decoder for the next set
  aisd_sel_if sel ();

  always_comb begin
    if (nxt_set == aisd_pkg::SET_B) begin
      sel.pos_code  = st_reg.ch0[aisd_pkg::C0_SB +: 6];
      sel.neg_bit   = st_reg.ch0[aisd_pkg::C0_NB];
      sel.multi_pos = {st_reg.multi[aisd_pkg::M_SB_HI +: 2],
                       st_reg.multi[aisd_pkg::M_SB_LO]};
      sel.multi_neg = st_reg.multi[aisd_pkg::M_NB +: 2];
    end else begin
      sel.pos_code  = st_reg.ch0[aisd_pkg::C0_SA +: 6];
      sel.neg_bit   = st_reg.ch0[aisd_pkg::C0_NA];
      sel.multi_pos = {st_reg.multi[aisd_pkg::M_SA_HI +: 2],
                       st_reg.multi[aisd_pkg::M_SA_LO]};
      sel.multi_neg = st_reg.multi[aisd_pkg::M_NA +: 2];
    end
  end

  assign sel.ref_cfg    = ref_cfg;
  assign sel.opamp_mode = opa_mode;
  assign sel.twelve_bit = twelve;

  aisd_sel_decode u_dec (
    .sel (sel.decode)
  );

  // ==========================================================
  // Next state
  always_comb begin
    st_next         = st_reg;
    st_next.rdata   = aisd_pkg::WORD_ZERO;
    st_next.dma_adv = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        aisd_pkg::ADDR_DMA_CFG: st_next.dma_cfg = reg_wdata & aisd_pkg::MASK_DMA_CFG;
        aisd_pkg::ADDR_MULTI:   st_next.multi = reg_wdata & aisd_pkg::MASK_MULTI;
        aisd_pkg::ADDR_CH0:     st_next.ch0 = reg_wdata & aisd_pkg::MASK_CH0;
        aisd_pkg::ADDR_CTRL:    st_next.ctrl = reg_wdata & aisd_pkg::MASK_CTRL;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        aisd_pkg::ADDR_DMA_CFG: st_next.rdata = st_reg.dma_cfg;
        aisd_pkg::ADDR_MULTI:   st_next.rdata = st_reg.multi;
        aisd_pkg::ADDR_CH0:     st_next.rdata = st_reg.ch0;
        aisd_pkg::ADDR_CTRL:    st_next.rdata = st_reg.ctrl;
        default:                st_next.rdata = aisd_pkg::WORD_ZERO;
      endcase
    end
    if (op_done) begin
      st_next.set = nxt_set;
      st_next.dec = sel.dec;
      if (dma_en) begin
        st_next.buf_idx = aisd_pkg::IDX_ZERO;
        if (st_reg.inc_cnt == inc_rate) begin
          st_next.dma_adv = 1'b1;
          st_next.inc_cnt = aisd_pkg::CNT_ZERO;
        end else begin
          st_next.inc_cnt = st_reg.inc_cnt + aisd_pkg::CNT_STEP;
        end
      end else begin
        st_next.buf_idx = st_reg.buf_idx + aisd_pkg::IDX_STEP;
        st_next.inc_cnt = aisd_pkg::CNT_ZERO;
      end
    end
    st_next.words = aisd_pkg::BUF_WORDS_RST << bw_code;
    st_next.ch_en = chan_map(ch_cnt, twelve);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg       <= '0;
      st_reg.words <= aisd_pkg::BUF_WORDS_RST;
      st_reg.ch_en <= aisd_pkg::CH_EN_ONE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata    = st_reg.rdata;
  assign sel_dec      = st_reg.dec;
  assign sel_set      = st_reg.set;
  assign chan_enable  = st_reg.ch_en;
  assign buf_index    = st_reg.buf_idx;
  assign dma_advance  = st_reg.dma_adv;
  assign buffer_words = st_reg.words;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_dma_op;
    op_done && dma_en;
  endsequence

  sequence s_fill_op;
    op_done && !dma_en;
  endsequence

  dma_index_a: assert property (s_dma_op |=> buf_index == aisd_pkg::IDX_ZERO)
    else $error("dma result not in first buffer");

  fill_index_a: assert property (s_fill_op |=> buf_index == 4'($past(buf_index) + 4'h1))
    else $error("buffer index did not step");

  no_dma_req_a: assert property (s_fill_op |=> !dma_advance)
    else $error("dma advance without dma");

  buf_words_a: assert property (##1 buffer_words == (8'h01 << $past(bw_code)))
    else $error("buffer words wrong");

  rate_hit_a: assert property (s_dma_op ##0 (st_reg.inc_cnt == inc_rate)
                               |=> dma_advance ##1 (!dma_advance || $past(op_done)))
    else $error("dma advance missed");

  rate_skip_a: assert property (s_dma_op ##0 (st_reg.inc_cnt != inc_rate)
                                |=> !dma_advance)
    else $error("dma advance early");

  alt_off_a: assert property (op_done && !alternate_sample_mode |=> sel_set == aisd_pkg::SET_A)
    else $error("set b used without alternate");

  alt_on_a: assert property (op_done && alternate_sample_mode |=> sel_set != $past(sel_set))
    else $error("set did not alternate");

  hold_sel_a: assert property (!op_done |=> $stable(sel_dec))
    else $error("selection changed mid operation");

  low_code_a: assert property (op_done && sel.multi_pos == 3'b000
                               |=> sel_dec.m_pos[0].ain == aisd_pkg::AIN_0 &&
                                   sel_dec.m_pos[2].ain == aisd_pkg::AIN_2)
    else $error("multi code 000 misrouted");

  top_code_a: assert property (op_done && sel.multi_pos[aisd_pkg::MP_TOP]
                               |=> sel_dec.m_pos[1].ain == aisd_pkg::AIN_25 &&
                                   sel_dec.m_pos[2].ain == aisd_pkg::AIN_6)
    else $error("multi top code misrouted");

  ref_ground_a: assert property (op_done && !sel.neg_bit && ref_cfg[1] == 1'b0
                                 |=> sel_dec.ch0_neg.kind == aisd_pkg::NG_GROUND)
    else $error("low reference not grounded");

  temp_sel_a: assert property (op_done && sel.pos_code == aisd_pkg::POS_TEMP
                               |=> sel_dec.ch0_pos.route == aisd_pkg::RT_TEMP)
    else $error("temperature input not routed");

  ten_bit_a: assert property (op_done && twelve && sel.pos_code >= aisd_pkg::POS_10B_LO
                              |=> sel_dec.ch0_pos.route != aisd_pkg::RT_PIN)
    else $error("high input used in 12-bit mode");

  opamp_sel_a: assert property (op_done && sel.pos_code == aisd_pkg::AIN_3 &&
                                opa_mode[aisd_pkg::OPA1]
                                |=> sel_dec.ch0_pos.route == aisd_pkg::RT_OPAMP)
    else $error("op amp output not used");

  unmapped_a: assert property (reg_rd && reg_addr > aisd_pkg::ADDR_CTRL
                               |=> reg_rdata == aisd_pkg::WORD_ZERO ##1
                                   reg_rdata == aisd_pkg::WORD_ZERO || $past(reg_rd))
    else $error("unmapped read not zero");

  chan_cnt_a: assert property (twelve || ch_cnt == aisd_pkg::CNT_CH0
                               |=> chan_enable == aisd_pkg::CH_EN_ONE)
    else $error("channel enables wrong");

  ch_two_a: assert property (!twelve && ch_cnt == aisd_pkg::CNT_CH01
                             |=> chan_enable == aisd_pkg::CH_EN_TWO)
    else $error("two channel enables wrong");

  ch_all_a: assert property (!twelve && ch_cnt[1]
                             |=> chan_enable == aisd_pkg::CH_EN_ALL)
    else $error("all channel enables wrong");

  code_345_a: assert property (op_done && sel.multi_pos == {1'b0, aisd_pkg::MP_AN345}
                               |=> sel_dec.m_pos[0].ain == aisd_pkg::AIN_3 &&
                                   sel_dec.m_pos[2].ain == aisd_pkg::AIN_5)
    else $error("multi code 001 misrouted");

  neg_high_a: assert property (op_done && sel.multi_neg == aisd_pkg::MN_HIGH
                               |=> sel_dec.m_neg[0].ain == aisd_pkg::AIN_9 &&
                                   sel_dec.m_neg[2].kind == aisd_pkg::NG_INPUT)
    else $error("multi negative misrouted");

  ch0_neg_a: assert property (op_done && sel.neg_bit
                              |=> sel_dec.ch0_neg.ain == aisd_pkg::AIN_1)
    else $error("channel 0 negative not input 1");

  ext_ref_a: assert property (op_done && !sel.neg_bit && ref_cfg[2:1] == 2'b01
                              |=> sel_dec.ch0_neg.kind == aisd_pkg::NG_EXT_REF)
    else $error("external low reference not used");

  pin_code_a: assert property (op_done && sel.pos_code == aisd_pkg::AIN_5
                               |=> sel_dec.ch0_pos == {aisd_pkg::RT_PIN, aisd_pkg::AIN_5})
    else $error("channel 0 input 5 misrouted");

  unconn_a: assert property (op_done && sel.pos_code == aisd_pkg::POS_NONE
                             |=> sel_dec.ch0_pos.route == aisd_pkg::RT_NONE)
    else $error("unconnected code routed");

endmodule // aisd_top
`default_nettype wire

// ==== tb/aisd_conv_model.sv ====
// Far-side model: conversion sequencer issuing op_done, counting DMA advances
`timescale 1ns/1ns
`default_nettype none
module aisd_conv_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Sequencer side
  input  wire logic       start,
  output var  logic       op_done,
  input  wire logic       dma_advance,
  output var  logic [7:0] adv_cnt
);
  // One operation ends one cycle after each start cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_done <= 1'b0;
      adv_cnt <= 8'h00;
    end else begin
      op_done <= start;
      adv_cnt <= adv_cnt + {7'h00, dma_advance};
    end
  end
endmodule // aisd_conv_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench: register port, input select decode and result buffer stepping
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  typedef struct {
    logic [15:0] c0, mu, ct;
    logic [7:0]  p0;
    logic [1:0]  nk, mr;
    logic [5:0]  a1, a2, a3;
    logic [1:0]  mk;
    logic [5:0]  mb;
  } aisd_tb_row_t;
  logic                 core_clk, resetn, reg_wr, reg_rd, start, op_done, dma_advance;
  aisd_pkg::aisd_addr_t reg_addr;
  aisd_pkg::aisd_word_t reg_wdata, reg_rdata, v;
  aisd_pkg::aisd_dec_t  sel_dec;
  aisd_pkg::aisd_set_t  sel_set, prev;
  logic [3:0]           chan_enable, buf_index;
  logic [7:0]           buffer_words, adv_cnt;
  aisd_pkg::aisd_word_t masks [5];
  aisd_tb_row_t         rows [8];
  int                   error_cnt, total_checks;
  aisd_top aisd_top_i (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_done(op_done), .sel_dec(sel_dec), .sel_set(sel_set), .chan_enable(chan_enable),
    .buf_index(buf_index), .dma_advance(dma_advance), .buffer_words(buffer_words));
  aisd_conv_model aisd_conv_model_i (.core_clk(core_clk), .resetn(resetn), .start(start),
    .op_done(op_done), .dma_advance(dma_advance), .adv_cnt(adv_cnt));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic wr(input aisd_pkg::aisd_addr_t a, input aisd_pkg::aisd_word_t d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input aisd_pkg::aisd_addr_t a);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic op();
    @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; start = 1'b0;
    reg_addr = 4'h0; reg_wdata = 16'h0000;
    masks = '{aisd_pkg::MASK_DMA_CFG, aisd_pkg::MASK_MULTI, aisd_pkg::MASK_CH0,
      aisd_pkg::MASK_CTRL, aisd_pkg::WORD_ZERO};
    rows = '{
      '{16'h0005, 16'h0006, 16'h0002, 8'h05, 2'h1, 2'h0, 6'h00, 6'h01, 6'h02, 2'h0, 6'h09},
      '{16'h00bf, 16'h0005, 16'h0001, 8'hff, 2'h0, 2'h0, 6'h03, 6'h04, 6'h05, 2'h0, 6'h06},
      '{16'h003e, 16'h0008, 16'h0000, 8'hbe, 2'h2, 2'h0, 6'h03, 6'h00, 6'h06, 2'h2, 6'h00},
      '{16'h0019, 16'h000b, 16'h0003, 8'h19, 2'h1, 2'h0, 6'h03, 6'h00, 6'h19, 2'h1, 6'h00},
      '{16'h0020, 16'h0011, 16'h0004, 8'h20, 2'h2, 2'h0, 6'h00, 6'h19, 6'h06, 2'h2, 6'h00},
      '{16'h0032, 16'h0018, 16'h0000, 8'hf2, 2'h2, 2'h0, 6'h00, 6'h19, 6'h06, 2'h2, 6'h00},
      '{16'h0000, 16'h0008, 16'hf000, 8'h40, 2'h2, 2'h1, 6'h03, 6'h00, 6'h06, 2'h2, 6'h00},
      '{16'h0006, 16'h0001, 16'h2000, 8'h06, 2'h2, 2'h0, 6'h03, 6'h04, 6'h05, 2'h2, 6'h00}};
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    `CHK("words", 8'h01, buffer_words)
    `CHK("enable", 4'h1, chan_enable)
    `CHK("dec", 64'h0, sel_dec)
    for (int a = 0; a < 5; a++) begin
      rd(4'(a));
      `CHK("reset_val", 16'h0000, v)
      wr(4'(a), 16'hffff);
      rd(4'(a));
      `CHK("mask", masks[a], v)
    end
    for (int k = 0; k < 8; k++) begin
      wr(aisd_pkg::ADDR_DMA_CFG, 16'(k));
      @(posedge core_clk);
      #1 `CHK("words", 8'h01 << k, buffer_words)
    end
    foreach (rows[i]) begin
      wr(aisd_pkg::ADDR_CH0, rows[i].c0);
      wr(aisd_pkg::ADDR_MULTI, rows[i].mu);
      wr(aisd_pkg::ADDR_CTRL, rows[i].ct);
      op();
      `CHK("ch0_pos", rows[i].p0, sel_dec.ch0_pos)
      `CHK("ch0_neg", rows[i].nk, sel_dec.ch0_neg.kind)
      `CHK("m_pos1", {rows[i].mr, rows[i].a1}, sel_dec.m_pos[0])
      `CHK("m_pos2", {rows[i].mr, rows[i].a2}, sel_dec.m_pos[1])
      `CHK("m_pos3", {rows[i].mr, rows[i].a3}, sel_dec.m_pos[2])
      `CHK("m_neg", rows[i].mk, sel_dec.m_neg[0].kind)
      if (rows[i].mk == 2'h0) `CHK("m_neg3", rows[i].mb + 6'h02, sel_dec.m_neg[2].ain)
      `CHK("set", aisd_pkg::SET_A, sel_set)
    end
    wr(aisd_pkg::ADDR_DMA_CFG, 16'h0100);
    wr(aisd_pkg::ADDR_CTRL, 16'h0080);
    for (int i = 0; i < 6; i++) begin
      op();
      `CHK("dma_index", 4'h0, buf_index)
      `CHK("advance", (i % 3) == 2, dma_advance)
    end
    wr(aisd_pkg::ADDR_DMA_CFG, 16'h0000);
    for (int i = 0; i < 17; i++) begin
      op();
      `CHK("index", 4'(i + 1), buf_index)
      `CHK("advance", 1'b0, dma_advance)
    end
    for (int k = 0; k < 4; k++) begin
      wr(aisd_pkg::ADDR_CTRL, 16'(k << 4));
      @(posedge core_clk);
      #1 `CHK("enable", (k == 0) ? 4'h1 : (k == 1) ? 4'h3 : 4'hf, chan_enable)
    end
    wr(aisd_pkg::ADDR_CH0, 16'h0704);
    wr(aisd_pkg::ADDR_MULTI, 16'h0900);
    wr(aisd_pkg::ADDR_CTRL, 16'h0008);
    op();
    for (int i = 0; i < 3; i++) begin
      prev = sel_set;
      op();
      `CHK("alt", ~prev, sel_set)
      `CHK("alt_pos", (sel_set == aisd_pkg::SET_B) ? 8'h07 : 8'h04, sel_dec.ch0_pos)
      `CHK("alt_m3", (sel_set == aisd_pkg::SET_B) ? 6'h19 : 6'h02, sel_dec.m_pos[2].ain)
    end
    wr(aisd_pkg::ADDR_CH0, 16'h0031);
    wr(aisd_pkg::ADDR_CTRL, 16'h0830);
    op();
    `CHK("twelve_en", 4'h1, chan_enable)
    `CHK("twelve_pos", aisd_pkg::RT_NONE, sel_dec.ch0_pos.route)
    wr(aisd_pkg::ADDR_CTRL, 16'h0000);
    op();
    `CHK("ten_pos", 8'h31, sel_dec.ch0_pos)
    wr(aisd_pkg::ADDR_CH0, 16'h0009);
    repeat (3) @(posedge core_clk);
    #1 `CHK("hold", 8'h31, sel_dec.ch0_pos)
    op();
    `CHK("boundary", 8'h09, sel_dec.ch0_pos)
    `CHK("model_adv", 8'h02, adv_cnt)
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(aisd_pkg::ADDR_CH0);
    `CHK("rereset", 16'h0000, v)
    `CHK("rereset_dec", 64'h0, sel_dec)
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
